// file: logic/csr_pkg.sv
// Package for the core state register file: offsets, fields, reset values, types.
// Assumes a 32-bit AXI4-Lite master with word-aligned accesses.
package csr_pkg;
  // Register byte offsets (AXI window)
  localparam logic [7:0] CSR_OFF_GPR0   = 8'h00; // Sixteen words, 0x00..0x3c
  localparam logic [7:0] CSR_OFF_PSW    = 8'h40;
  localparam logic [7:0] CSR_OFF_PC     = 8'h44;
  localparam logic [7:0] CSR_OFF_TBR    = 8'h48;
  localparam logic [7:0] CSR_OFF_RAR    = 8'h4c;
  localparam logic [7:0] CSR_OFF_USP    = 8'h50;
  localparam logic [7:0] CSR_OFF_MDH    = 8'h54;
  localparam logic [7:0] CSR_OFF_MDL    = 8'h58;
  localparam logic [7:0] CSR_OFF_MODE   = 8'h5c;
  localparam logic [7:0] CSR_OFF_CTRL   = 8'h60;
  // Status word fields
  localparam int CSR_ILM_LSB = 16;
  localparam int CSR_ILM_MSB = 20;
  localparam int CSR_SCR_LSB = 8;
  localparam int CSR_SCR_MSB = 10;
  localparam int CSR_CCR_LSB = 0;
  localparam int CSR_CCR_MSB = 7;
  localparam int CSR_STACK_SEL_BIT = 5;
  localparam int CSR_INT_EN_BIT = 4;
  localparam int CSR_TRACE_BIT = 8;
  localparam logic [31:0] CSR_PSW_MASK = 32'h001f_077f;
  // Reset values, boot mode fetch constants, interrupt entry length
  localparam logic [31:0] CSR_SP_RESET  = 32'h0000_0000;
  localparam logic [4:0]  CSR_ILM_RESET = 5'h0f;
  localparam logic [31:0] CSR_TBR_RESET = 32'h000f_fc00;
  localparam logic [31:0] CSR_MODE_ADDR = 32'h000f_fff8;
  localparam logic [7:0]  CSR_MODE_DATA = 8'h07;
  localparam int          CSR_IRQ_ENTRY_CYC = 6;
  // AXI responses
  localparam logic [1:0] CSR_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CSR_RESP_SLVERR = 2'h2;

  // Core event carrier
  typedef struct packed {
    logic        call;       // Subroutine call
    logic        ret;        // Subroutine return
    logic        irq_ret;    // Return from interrupt
    logic        irq_req;    // Interrupt request
    logic [3:0]  irq_level;
    logic [31:0] next_pc;
  } csr_core_ev_t;

  // Boot fetch states
  typedef enum logic [2:0] {
    CSR_BOOT_FETCH = 3'b001,
    CSR_BOOT_WAIT  = 3'b010,
    CSR_BOOT_RUN   = 3'b100
  } csr_boot_st_t;

  function automatic logic [31:0] csr_psw_clean(input logic [31:0] v);
    return v & CSR_PSW_MASK;
  endfunction
endpackage

// file: logic/csr_core_regs.sv
// Core architectural state registers with boot mode loading and AXI4-Lite access.
// Assumes single clock, synchronous active-high reset, core events synchronous.
`timescale 1ns/1ps
// What this block does
// - Sixteen 32-bit registers; stack register resets zero
// - Registers 13,14,15: accumulator, frame, stack roles
// - Status word built from mask, system, condition
// - Reserved status bits read zero, ignore writes
// - Condition field holds mode and result flags
// - System field: two multiply flags, trace enable
// - Five-bit level mask resets to 01111
// - Program counter tracks executing instruction
// - Vector table base resets to 000ffc00
// - Call copies program counter to return register
// - Return loads program counter from return register
// - Stack select routes register 15 to user
// - Interrupt return never uses user stack pointer
// - Multiply/divide result registers, 32 bits each
// - Interrupt entry in six cycles, level masked
// - Instruction and data ports independent
// - Mode register loaded from fetch after reset
// - Mode register writable only by emulator bytes
module csr_core_regs
  import csr_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  reset_i,
  // Boot straps and emulator
  input  wire logic [3:0]            boot_strap_pin_i,
  input  wire logic                  emulator_mode_i,
  // Instruction fetch port for mode vector
  output logic                       ifetch_req_o,
  output logic [31:0]                ifetch_addr_o,
  input  wire logic                  ifetch_ack_i,
  input  wire logic [31:0]           ifetch_data_i,
  // Core events
  input  wire csr_pkg::csr_core_ev_t core_ev_i,
  output logic                       irq_entry_done_o,
  output logic [31:0]                stack_alias_o,
  output logic                       boot_done_o,
  // AXI4-Lite slave
  input  wire logic [7:0]            s_awaddr_i,
  input  wire logic                  s_awvalid_i,
  output logic                       s_awready_o,
  input  wire logic [31:0]           s_wdata_i,
  input  wire logic [3:0]            s_wstrb_i,
  input  wire logic                  s_wvalid_i,
  output logic                       s_wready_o,
  output logic [1:0]                 s_bresp_o,
  output logic                       s_bvalid_o,
  input  wire logic                  s_bready_i,
  input  wire logic [7:0]            s_araddr_i,
  input  wire logic                  s_arvalid_i,
  output logic                       s_arready_o,
  output logic [31:0]                s_rdata_o,
  output logic [1:0]                 s_rresp_o,
  output logic                       s_rvalid_o,
  input  wire logic                  s_rready_i
);
  import csr_pkg::*;

  logic [31:0]  gpr_r [0:15];
  logic [31:0]  psw_r;
  logic [31:0]  pc_r;
  logic [31:0]  tbr_r;
  logic [31:0]  rar_r;
  logic [31:0]  usp_r;
  logic [31:0]  mdh_r;
  logic [31:0]  mdl_r;
  logic [7:0]   mode_r;
  logic         strap_bad_r;
  csr_boot_st_t boot_r;
  logic [2:0]   irq_cnt_r;
  logic         irq_busy_r;
  // Level held from acceptance; the request itself is only a pulse
  logic [3:0]   irq_lvl_r;
  logic         irq_take;
  logic         int_en;
  // AXI write latch
  logic         aw_got_r;
  logic         w_got_r;
  logic [7:0]   aw_addr_r;
  logic [31:0]  w_data_r;
  logic [3:0]   w_strb_r;
  logic         wr_fire;
  logic         wr_hit;
  logic         stack_sel;
  logic [4:0]   interrupt_level_mask;

  assign stack_sel = psw_r[CSR_STACK_SEL_BIT];
  assign interrupt_level_mask       = psw_r[CSR_ILM_MSB:CSR_ILM_LSB];
  assign int_en    = psw_r[CSR_INT_EN_BIT];

  // Request taken only when enabled and its level numerically strictly below the current mask
  assign irq_take  = !irq_busy_r && core_ev_i.irq_req && int_en
                     && ({1'b0, core_ev_i.irq_level} < interrupt_level_mask);

  // Register 15 view: user pointer when stack select set
  assign stack_alias_o = stack_sel ? usp_r : gpr_r[15];

  // Address decode shared by read and write
  function automatic logic csr_mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= CSR_OFF_CTRL);
  endfunction

  // Write channel capture, either order
  // Ready stays low while a response waits, so one write at a time
  assign s_awready_o = !aw_got_r && !s_bvalid_o;
  assign s_wready_o  = !w_got_r && !s_bvalid_o;
  assign wr_fire     = aw_got_r && w_got_r && !s_bvalid_o;
  assign wr_hit      = csr_mapped(aw_addr_r);

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end
    else
    begin
      if (s_awvalid_i && s_awready_o)
      begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= s_awaddr_i;
      end
      if (s_wvalid_i && s_wready_o)
      begin
        w_got_r  <= 1'b1;
        w_data_r <= s_wdata_i;
        w_strb_r <= s_wstrb_i;
      end
      if (wr_fire)
      begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
      end
    end
  end

  // Write response one cycle after both halves are held
  // Response drops on bready alone, since bvalid is already up then
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      s_bvalid_o <= 1'b0;
      s_bresp_o  <= CSR_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_bvalid_o <= 1'b1;
      s_bresp_o  <= wr_hit ? CSR_RESP_OKAY : CSR_RESP_SLVERR;
    end
    else if (s_bready_i)
    begin
      s_bvalid_o <= 1'b0;
    end
  end

  // General registers; only the stack register has a reset value
  // Registers 0..14 come up unknown; software must load them before use
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      gpr_r[15] <= CSR_SP_RESET;
    end
    else if (wr_fire && (aw_addr_r < CSR_OFF_PSW) && (aw_addr_r[1:0] == 2'h0))
    begin
      if ((aw_addr_r[5:2] != 4'hf) || !stack_sel)
        gpr_r[aw_addr_r[5:2]] <= w_data_r;
    end
  end

  // User stack pointer: own slot or register 15 while selected
  // Interrupt return neither loads nor saves it
  always_ff @(posedge clk_i)
  begin
    if (wr_fire && (aw_addr_r == CSR_OFF_USP))
      usp_r <= w_data_r;
    else if (wr_fire && (aw_addr_r == 8'h3c) && stack_sel)
      usp_r <= w_data_r;
  end

  // Status word; reserved bits masked on every write
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      psw_r                          <= 32'h0000_0000;
      psw_r[CSR_ILM_MSB:CSR_ILM_LSB] <= CSR_ILM_RESET;
      psw_r[CSR_TRACE_BIT]           <= 1'b0;
    end
    else if (wr_fire && (aw_addr_r == CSR_OFF_PSW))
    begin
      psw_r <= csr_psw_clean(w_data_r);
    end
    else if (irq_busy_r && (irq_cnt_r == 3'(CSR_IRQ_ENTRY_CYC - 1)))
    begin
      // Entry sets the mask to the level latched at acceptance;
      // the live request input has already dropped by now
      psw_r[CSR_ILM_MSB:CSR_ILM_LSB] <= {1'b0, irq_lvl_r};
    end
  end

  // Program counter follows core, return register handles call/return
  // No bus write reaches the counter; a write to its slot is dropped
  always_ff @(posedge clk_i)
  begin
    if (core_ev_i.ret)
      pc_r <= rar_r;
    else
      pc_r <= core_ev_i.next_pc;
  end

  // A call wins over a bus write landing in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (core_ev_i.call)
      rar_r <= pc_r;
    else if (wr_fire && (aw_addr_r == CSR_OFF_RAR))
      rar_r <= w_data_r;
  end

  // Vector table base
  // Strobes are not looked at; every write lands as a whole word
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      tbr_r <= CSR_TBR_RESET;
    else if (wr_fire && (aw_addr_r == CSR_OFF_TBR))
      tbr_r <= w_data_r;
  end

  // Multiply/divide results, no reset value
  // Loaded from the bus only here; the arithmetic unit lies outside
  always_ff @(posedge clk_i)
  begin
    if (wr_fire && (aw_addr_r == CSR_OFF_MDH))
      mdh_r <= w_data_r;
    if (wr_fire && (aw_addr_r == CSR_OFF_MDL))
      mdl_r <= w_data_r;
  end

  // Interrupt entry counter; a request arriving before entry is done is not taken or held
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      irq_busy_r       <= 1'b0;
      irq_cnt_r        <= 3'h0;
      irq_lvl_r        <= 4'h0;
      irq_entry_done_o <= 1'b0;
    end
    else
    begin
      irq_entry_done_o <= 1'b0;
      if (irq_take)
      begin
        irq_busy_r <= 1'b1;
        irq_cnt_r  <= 3'h0;
        irq_lvl_r  <= core_ev_i.irq_level;
      end
      else if (irq_busy_r)
      begin
        irq_cnt_r <= irq_cnt_r + 3'h1;
        if (irq_cnt_r == 3'(CSR_IRQ_ENTRY_CYC - 1))
        begin
          irq_busy_r       <= 1'b0;
          irq_entry_done_o <= 1'b1;
        end
      end
    end
  end

  // Boot: fetch mode word on the instruction port, separate from the AXI data path
  // Fetch is offered once per reset; the bus side stays usable meanwhile
  assign ifetch_addr_o = CSR_MODE_ADDR;
  assign ifetch_req_o  = (boot_r == CSR_BOOT_WAIT);
  assign boot_done_o   = (boot_r == CSR_BOOT_RUN);

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      boot_r <= CSR_BOOT_FETCH;
    else
    begin
      unique case (boot_r)
        CSR_BOOT_FETCH: boot_r <= CSR_BOOT_WAIT;
        CSR_BOOT_WAIT:  if (ifetch_ack_i) boot_r <= CSR_BOOT_RUN;
        CSR_BOOT_RUN:   boot_r <= CSR_BOOT_RUN;
        default:        boot_r <= CSR_BOOT_FETCH;
      endcase
    end
  end

  // Straps caught after release; illegal settings flagged only
  // Only the internal fetch exists, so a bad strap cannot redirect boot
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      strap_bad_r <= 1'b0;
    else if (boot_r == CSR_BOOT_FETCH)
      strap_bad_r <= (boot_strap_pin_i != 4'h0);
  end

  // Mode register: boot byte, then emulator byte writes only
  // Byte lane 0 alone; wider emulator writes are dropped
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      mode_r <= 8'h00;
    else if ((boot_r == CSR_BOOT_WAIT) && ifetch_ack_i)
      mode_r <= ifetch_data_i[31:24];
    else if (wr_fire && (aw_addr_r == CSR_OFF_MODE) && emulator_mode_i
             && (w_strb_r == 4'h1))
      mode_r <= w_data_r[7:0];
  end

  // Read channel, answer one cycle after address taken
  // Unknown offsets answer SLVERR; unaligned ones below 0x40 read a general register, all others read zero
  assign s_arready_o = !s_rvalid_o;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      s_rvalid_o <= 1'b0;
      s_rdata_o  <= 32'h0000_0000;
      s_rresp_o  <= CSR_RESP_OKAY;
    end
    else if (s_arvalid_i && s_arready_o)
    begin
      s_rvalid_o <= 1'b1;
      s_rresp_o  <= csr_mapped(s_araddr_i) ? CSR_RESP_OKAY : CSR_RESP_SLVERR;
      if (s_araddr_i == 8'h3c)
        s_rdata_o <= stack_alias_o;
      else if (s_araddr_i < CSR_OFF_PSW)
        s_rdata_o <= gpr_r[s_araddr_i[5:2]];
      else
      begin
        unique case (s_araddr_i)
          CSR_OFF_PSW:  s_rdata_o <= csr_psw_clean(psw_r);
          CSR_OFF_PC:   s_rdata_o <= pc_r;
          CSR_OFF_TBR:  s_rdata_o <= tbr_r;
          CSR_OFF_RAR:  s_rdata_o <= rar_r;
          CSR_OFF_USP:  s_rdata_o <= usp_r;
          CSR_OFF_MDH:  s_rdata_o <= mdh_r;
          CSR_OFF_MDL:  s_rdata_o <= mdl_r;
          CSR_OFF_MODE: s_rdata_o <= {24'h000000, mode_r};
          CSR_OFF_CTRL: s_rdata_o <= {29'h0, strap_bad_r, irq_busy_r, boot_done_o};
          default:      s_rdata_o <= 32'h0000_0000;
        endcase
      end
    end
    else if (s_rready_i)
    begin
      s_rvalid_o <= 1'b0;
    end
  end
endmodule

// file: bench/csr_monitor.sv
// Port checker for the core state register file.
// Assumes it is bound onto csr_core_regs; one clock, sync reset.
`timescale 1ns/1ps
module csr_monitor
  import csr_pkg::*;
(
  // Watched ports
  input wire logic                  clk_i,
  input wire logic                  reset_i,
  input wire logic                  ifetch_req_o,
  input wire logic [31:0]           ifetch_addr_o,
  input wire logic                  ifetch_ack_i,
  input wire csr_pkg::csr_core_ev_t core_ev_i,
  input wire logic                  irq_entry_done_o,
  input wire logic                  boot_done_o,
  input wire logic [7:0]            s_araddr_i,
  input wire logic                  s_arvalid_i,
  input wire logic                  s_arready_o,
  input wire logic [31:0]           s_rdata_o,
  input wire logic                  s_rvalid_o,
  input wire logic                  s_rready_i,
  input wire logic [1:0]            s_bresp_o,
  input wire logic                  s_bvalid_o,
  input wire logic                  s_bready_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Boot handshake and status read steps
  sequence s_mode_ack;
    ifetch_req_o && ifetch_ack_i;
  endsequence
  sequence s_psw_take;
    s_arvalid_i && s_arready_o && s_araddr_i == CSR_OFF_PSW;
  endsequence
  a_boot_addr: assert property (ifetch_req_o |-> ifetch_addr_o == CSR_MODE_ADDR)
    else $error("mode fetch address wrong");
  a_boot_load: assert property (s_mode_ack |=> boot_done_o && !ifetch_req_o)
    else $error("mode word not taken");
  a_boot_stays: assert property (boot_done_o |=> boot_done_o)
    else $error("boot done dropped");
  a_psw_reserved: assert property (s_psw_take |=> (s_rdata_o & ~CSR_PSW_MASK) == 32'h0)
    else $error("reserved status bits set");
  a_read_answer: assert property (s_arvalid_i && s_arready_o |=> s_rvalid_o)
    else $error("read answer late");
  a_rvalid_hold: assert property (s_rvalid_o && !s_rready_i |=> s_rvalid_o && $stable(s_rdata_o))
    else $error("read data not held");
  a_bvalid_hold: assert property (s_bvalid_o && !s_bready_i |=> s_bvalid_o && $stable(s_bresp_o))
    else $error("write response not held");
  a_irq_entry: assert property (irq_entry_done_o |-> $past(core_ev_i.irq_req, 7))
    else $error("interrupt entry not six cycles");
  a_irq_pulse: assert property (irq_entry_done_o |=> !irq_entry_done_o)
    else $error("entry done not a pulse");
endmodule
bind csr_core_regs csr_monitor u_mon (.clk_i, .reset_i, .ifetch_req_o, .ifetch_addr_o,
  .ifetch_ack_i, .core_ev_i, .irq_entry_done_o, .boot_done_o, .s_araddr_i, .s_arvalid_i,
  .s_arready_o, .s_rdata_o, .s_rvalid_o, .s_rready_i, .s_bresp_o, .s_bvalid_o, .s_bready_i);

// file: bench/tb_csr_core_regs.sv
// Self-checking bench for the core state register file.
// Assumes AXI4-Lite timing as handed over; bench answers the mode fetch.
`timescale 1ns/1ps
module tb_csr_core_regs;
  import csr_pkg::*;
  logic clk_i, reset_i, emulator_mode_i, ifetch_ack_i, ifetch_req_o, irq_entry_done_o;
  logic boot_done_o, s_awvalid_i, s_awready_o, s_wvalid_i, s_wready_o, s_bvalid_o;
  logic s_bready_i, s_arvalid_i, s_arready_o, s_rvalid_o, s_rready_i;
  logic [3:0]   boot_strap_pin_i, s_wstrb_i;
  logic [31:0]  ifetch_addr_o, ifetch_data_i, stack_alias_o, s_wdata_i, s_rdata_o, rdat;
  logic [7:0]   s_awaddr_i, s_araddr_i;
  logic [1:0]   s_bresp_o, s_rresp_o, bres, rres;
  csr_core_ev_t core_ev_i;
  int           num_errors, n_tests, cyc;
  logic [7:0]   offs [4] = '{8'h34, 8'h38, 8'h54, 8'h58};
  csr_core_regs uut (.clk_i, .reset_i, .boot_strap_pin_i, .emulator_mode_i, .ifetch_req_o,
    .ifetch_addr_o, .ifetch_ack_i, .ifetch_data_i, .core_ev_i, .irq_entry_done_o,
    .stack_alias_o, .boot_done_o, .s_awaddr_i, .s_awvalid_i, .s_awready_o, .s_wdata_i,
    .s_wstrb_i, .s_wvalid_i, .s_wready_o, .s_bresp_o, .s_bvalid_o, .s_bready_i, .s_araddr_i,
    .s_arvalid_i, .s_arready_o, .s_rdata_o, .s_rresp_o, .s_rvalid_o, .s_rready_i);
  // Clock, 100 ns period
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Hang guard, well above the fewer than two hundred cycles needed
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      num_errors++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st);
    logic aw, w, b;
    b = 1'b0;
    @(posedge clk_i);
    s_awaddr_i <= a;
    s_awvalid_i <= 1'b1;
    s_wdata_i <= d;
    s_wstrb_i <= st;
    s_wvalid_i <= 1'b1;
    s_bready_i <= 1'b1;
    while (!b)
    begin
      @(negedge clk_i);
      aw = s_awvalid_i && s_awready_o;
      w = s_wvalid_i && s_wready_o;
      b = s_bvalid_o;
      bres = s_bresp_o;
      @(posedge clk_i);
      if (aw) s_awvalid_i <= 1'b0;
      if (w) s_wvalid_i <= 1'b0;
      if (b) s_bready_i <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a);
    logic ar, r;
    r = 1'b0;
    @(posedge clk_i);
    s_araddr_i <= a;
    s_arvalid_i <= 1'b1;
    s_rready_i <= 1'b1;
    while (!r)
    begin
      @(negedge clk_i);
      ar = s_arvalid_i && s_arready_o;
      r = s_rvalid_o;
      rdat = s_rdata_o;
      rres = s_rresp_o;
      @(posedge clk_i);
      if (ar) s_arvalid_i <= 1'b0;
      if (r) s_rready_i <= 1'b0;
    end
  endtask
  // One-cycle core event; program counter value stays afterwards
  task automatic ev(input logic c, input logic x, input logic q, input logic [3:0] l,
                    input logic [31:0] p);
    @(posedge clk_i);
    core_ev_i <= '{call: c, ret: 1'b0, irq_ret: x, irq_req: q, irq_level: l, next_pc: p};
    @(posedge clk_i);
    core_ev_i <= '{call: 1'b0, ret: 1'b0, irq_ret: 1'b0, irq_req: 1'b0,
                   irq_level: 4'h0, next_pc: p};
  endtask
  initial
  begin
    {emulator_mode_i, ifetch_ack_i, s_awvalid_i, s_wvalid_i, s_bready_i} = '0;
    {s_arvalid_i, s_rready_i, s_awaddr_i, s_araddr_i, s_wdata_i, s_wstrb_i} = '0;
    {num_errors, n_tests} = '0;
    boot_strap_pin_i = 4'h0;
    ifetch_data_i = 32'h0;
    core_ev_i = '0;
    reset_i = 1'b1;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    // Answer the mode vector fetch
    while (ifetch_req_o !== 1'b1) @(negedge clk_i);
    chk(ifetch_addr_o, CSR_MODE_ADDR, "fetch address");
    @(posedge clk_i);
    ifetch_ack_i <= 1'b1;
    ifetch_data_i <= {CSR_MODE_DATA, 24'hf0f0f0};
    @(posedge clk_i);
    ifetch_ack_i <= 1'b0;
    ifetch_data_i <= ~{CSR_MODE_DATA, 24'hf0f0f0};
    @(negedge clk_i);
    chk(boot_done_o, 1'b1, "boot done");
    rd(CSR_OFF_MODE);
    chk(rdat[7:0], CSR_MODE_DATA, "mode");
    rd(8'h3c);
    chk(rdat, CSR_SP_RESET, "stack reset");
    rd(CSR_OFF_TBR);
    chk(rdat, CSR_TBR_RESET, "table base");
    rd(CSR_OFF_PSW);
    chk({rdat[20:16], rdat[8]}, {CSR_ILM_RESET, 1'b0}, "status reset");
    wr(CSR_OFF_PSW, 32'hffffffff, 4'hf);
    chk(bres, CSR_RESP_OKAY, "write response");
    rd(CSR_OFF_PSW);
    chk(rdat, CSR_PSW_MASK, "status mask");
    // Stack select routes register fifteen
    wr(CSR_OFF_PSW, 32'h0, 4'hf);
    wr(8'h3c, 32'h1111_2222, 4'hf);
    wr(CSR_OFF_USP, 32'h3333_4444, 4'hf);
    wr(CSR_OFF_PSW, 32'h20, 4'hf);
    rd(8'h3c);
    chk(rdat, 32'h3333_4444, "user stack");
    chk(stack_alias_o, 32'h3333_4444, "stack alias");
    wr(CSR_OFF_PSW, 32'h0, 4'hf);
    rd(8'h3c);
    chk(rdat, 32'h1111_2222, "supervisor stack");
    // Interrupt return must leave the user pointer alone
    ev(1'b0, 1'b1, 1'b0, 4'h0, 32'h0000_1234);
    rd(CSR_OFF_USP);
    chk(rdat, 32'h3333_4444, "user stack on return");
    foreach (offs[i])
    begin
      wr(offs[i], {24'ha5c3e1, offs[i]}, 4'hf);
      rd(offs[i]);
      chk(rdat, {24'ha5c3e1, offs[i]}, "gpr or muldiv");
    end
    // Call copies the running program counter
    ev(1'b0, 1'b0, 1'b0, 4'h0, 32'h0000_1234);
    ev(1'b1, 1'b0, 1'b0, 4'h0, 32'h0000_1234);
    rd(CSR_OFF_PC);
    chk(rdat, 32'h0000_1234, "program counter");
    rd(CSR_OFF_RAR);
    chk(rdat, 32'h0000_1234, "return pointer");
    // Return reloads the counter; a call on the next edge copies it back
    wr(CSR_OFF_RAR, 32'h0000_4444, 4'hf);
    @(posedge clk_i);
    core_ev_i.ret <= 1'b1;
    @(posedge clk_i);
    core_ev_i.ret <= 1'b0;
    core_ev_i.call <= 1'b1;
    @(posedge clk_i);
    core_ev_i.call <= 1'b0;
    rd(CSR_OFF_RAR);
    chk(rdat, 32'h0000_4444, "return to counter");
    // Mode register: only emulator byte writes land
    for (int k = 0; k < 3; k++)
    begin
      emulator_mode_i <= (k != 0);
      wr(CSR_OFF_MODE, 32'h5a + k, (k == 1) ? 4'hf : 4'h1);
      rd(CSR_OFF_MODE);
      chk(rdat[7:0], (k == 2) ? 8'h5c : CSR_MODE_DATA, "mode write");
    end
    rd(8'h80);
    chk(rres, CSR_RESP_SLVERR, "unmapped read");
    wr(8'h80, 32'h0000_0001, 4'hf);
    chk(bres, CSR_RESP_SLVERR, "unmapped write");
    // Interrupt entry lowers the level mask
    wr(CSR_OFF_PSW, 32'h000f_0010, 4'hf);
    ev(1'b0, 1'b0, 1'b1, 4'h3, 32'h0000_1234);
    repeat (8) @(posedge clk_i);
    rd(CSR_OFF_PSW);
    chk(rdat[20:16], 5'h03, "level mask");
    final_report();
  end
endmodule
